/* File: design/cmp_pkg.sv */
// Package: register map, field layout, reset values and carriers for the comparator back end
// Behaviour
// [RULE1] Sync bit routes output through timer-clocked latch
// [RULE2] Latch captures on timer clock falling edge
// [RULE3] Prescaled timer clock clocks the latch
// [RULE4] Timer counts on rising edge of clock
// [RULE5] Separate rise and fall detectors per comparator
// [RULE6] Enabled detector firing sets interrupt flag
// [RULE7] Request needs all enables set by software; the code also needs the on, polarity and speed bits set
// [RULE8] Flag stays set until software clears
// [RULE9] Edge during clear leaves flag set
// [RULE10] Polarity or on toggles can raise flag
// [RULE11] Two-bit field picks plus input source
// [RULE12] Power off disconnects all input selections
// [RULE13] Minus select bit picks inverting pin
// [RULE14] Outputs feed output generator shutdown inputs
// [RULE15] Output register mirrors both comparator outputs
// [RULE16] Edges detected on final output, system clock
package cmp_pkg;
   // Register offsets on the plain register port
   localparam logic [3:0] CTRL0_C1_OFS   = 4'h0;   // Comparator 1 control 0
   localparam logic [3:0] CTRL1_C1_OFS   = 4'h1;   // Comparator 1 control 1
   localparam logic [3:0] CTRL0_C2_OFS   = 4'h2;   // Comparator 2 control 0
   localparam logic [3:0] CTRL1_C2_OFS   = 4'h3;   // Comparator 2 control 1
   localparam logic [3:0] MIRROR_OFS     = 4'h4;   // Read-only output mirror
   localparam logic [3:0] IRQ_FLAG_OFS   = 4'h5;   // Interrupt flags, write 0 clears
   localparam logic [3:0] IRQ_EN_OFS     = 4'h6;   // Per-comparator and global enables
   localparam logic [3:0] TIMER_OFS      = 4'h7;   // Timer count, read only
   localparam logic [3:0] TIMER_CFG_OFS  = 4'h8;   // Timer prescaler select
   // Control 0 fields
   localparam int ON_BIT     = 7;
   localparam int OUT_BIT    = 6;
   localparam int POL_BIT    = 4;
   localparam int SPEED_BIT  = 2;
   localparam int SYNC_BIT   = 0;
   // Control 1 fields
   localparam int RISE_BIT   = 7;
   localparam int FALL_BIT   = 6;
   localparam int PCH_LSB    = 3;
   localparam int NCH_BIT    = 0;
   // Enable register fields
   localparam int PERIPH_BIT = 6;
   localparam int GLOBAL_BIT = 7;
   // Reset values
   localparam logic [7:0] CTRL0_RST  = 8'h04;
   localparam logic [7:0] CTRL1_RST  = 8'h00;
   localparam logic [7:0] ZERO8      = 8'h00;
   localparam logic [1:0] PRESC_RST  = 2'h0;
   // Plus input sources
   localparam logic [1:0] PLUS_PIN   = 2'h0;
   localparam logic [1:0] PLUS_DAC   = 2'h1;
   localparam logic [1:0] PLUS_FVR   = 2'h2;
   localparam logic [1:0] PLUS_GND   = 2'h3;

   // Register bus request
   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   // Analog routing for one comparator, one-hot
   typedef struct packed
   {
      logic [3:0] plus_sel;   // pin, dac, fixed_voltage_ref, ground
      logic [1:0] minus_sel;  // pin 0, pin 1
      logic       power;
      logic       speed;
   } route_t;
endpackage

/* File: design/cmp_sync_latch.sv */
// Timer on the timer clock with a falling-edge output latch
module cmp_sync_latch
(
   // Timer clock and reset
   input  wire logic       tmr_clk,
   input  wire logic       rst_n,
   // Prescaler select and raw comparator levels
   input  wire logic [1:0] presc_sel,
   input  wire logic [1:0] raw_out,
   // Latched levels and count
   output logic [1:0]      latched_out,
   output logic [7:0]      count
);
   import cmp_pkg::*;

   // Rising-edge domain state
   typedef struct packed
   {
      logic [2:0] div;
      logic       tick;
      logic [7:0] count;
   } rise_t;

   rise_t rs_ff;      // Registered state
   rise_t nxt_rs;     // Next state
   logic  presc_clk;  // Prescaled clock level
   logic [1:0] lat_ff; // Falling-edge latch

   // Prescaler divides by 1,2,4,8
   always_comb
   begin
      nxt_rs = rs_ff;
      nxt_rs.div = rs_ff.div + 3'h1;
      case (presc_sel)
         2'h0: nxt_rs.tick = 1'b1;
         2'h1: nxt_rs.tick = rs_ff.div[0];
         2'h2: nxt_rs.tick = &rs_ff.div[1:0];
         default: nxt_rs.tick = &rs_ff.div;
      endcase
      if (nxt_rs.tick)
      begin
         nxt_rs.count = rs_ff.count + 8'h01;  // [RULE4]
      end
   end

   // Counter on rising edge, so it never races the latch
   always_ff @(posedge tmr_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rs_ff <= '0;
      end
      else
      begin
         rs_ff <= nxt_rs;  // [RULE4]
      end
   end

   // Raw clock when undivided, else the prescaled enable gate
   assign presc_clk = (presc_sel == PRESC_RST) ? 1'b1 : rs_ff.tick;

   // Latch on falling edge, only in cycles the prescaled clock pulses
   always_ff @(negedge tmr_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lat_ff <= 2'h0;
      end
      else if (presc_clk)  // [RULE3]
      begin
         lat_ff <= raw_out;  // [RULE2]
      end
   end

   assign latched_out = lat_ff;
   assign count       = rs_ff.count;
endmodule

/* File: design/cmp_backend.sv */
// Two comparator digital back end: sync, polarity, edge flags, routing, mirror
//
// Strobed register access and the register addresses were decided locally.
module cmp_backend
(
   // Clock and reset
   input  wire logic              MCLK,
   input  wire logic              RST_N,
   // Register port
   input  wire cmp_pkg::bus_req_t BUS,
   output logic [7:0]             RDATA,
   // Timer source clock and analog comparator raw outputs
   input  wire logic              TMR_CLK,
   input  wire logic [1:0]        ANALOG_OUT,
   // Analog routing
   output cmp_pkg::route_t        ROUTE_C1,
   output cmp_pkg::route_t        ROUTE_C2,
   // Shutdown sources and interrupt request
   output logic [1:0]             SHUTDOWN_SRC,
   output logic                   IRQ
);
   import cmp_pkg::*;

   // Module state apart from the synchronisers and the timer
   typedef struct packed
   {
      logic [1:0][7:0] ctrl0;     // Control 0 per comparator
      logic [1:0][7:0] ctrl1;     // Control 1 per comparator
      logic [1:0]      flag;      // cmp_irq_flag
      logic [7:0]      irq_en;    // Enables
      logic [1:0]      presc;     // Timer prescaler
      logic [1:0]      out_prev;  // Last final output
      logic [1:0]      sd;        // Shutdown outputs
      logic [7:0]      rdata;     // Read data
      logic [1:0]      irq;       // Request level
   } state_t;

   state_t st_ff;        // Registered state
   state_t nxt_st;       // Next state
   logic [1:0] ana_s1;   // First sync stage
   logic [1:0] ana_s2;   // Second sync stage
   logic [1:0] lat_s1;   // Latch sync first stage
   logic [1:0] lat_s2;   // Latch sync second stage
   logic [1:0] lat_raw;  // Latch output, timer domain
   logic [7:0] tcount;   // Timer count, timer domain
   logic [7:0] t_s1;     // Count sync first stage
   logic [7:0] t_s2;     // Count sync second stage
   logic [7:0] t_s3;     // Count sync third stage, for the agreement test
   logic [7:0] t_hold;   // Last count seen steady across two samples
   logic [1:0] final_out; // After sync and polarity
   logic [1:0] rise;     // Rising detector
   logic [1:0] fall;     // Falling detector

   // Timer and falling-edge latch live on the timer clock
   cmp_sync_latch u_latch
   (
      .tmr_clk     (TMR_CLK),
      .rst_n       (RST_N),
      .presc_sel   (st_ff.presc),
      .raw_out     (ANALOG_OUT),
      .latched_out (lat_raw),
      .count       (tcount)
   );

   // Output level of one comparator; off forces a low, then polarity
   // Polarity is applied after the power gate on purpose: flipping the
   // polarity of a powered-down comparator still moves the final output,
   // so the edge detectors see it and may raise the flag.
   // The synchronised path is chosen before the power gate, so turning the
   // comparator off also forces the latched level out of the picture.
   function automatic logic cmp_level(input logic [7:0] c0, input logic synced,
                                      input logic direct);
      logic v;
      v = c0[SYNC_BIT] ? synced : direct;  // [RULE1]
      v = c0[ON_BIT] & v;
      return v ^ c0[POL_BIT];  // [RULE10]
   endfunction

   // Route decode; selects all off while powered down
   // Selects are one-hot so the analog switches never short two sources.
   // Power and speed pass straight through; the selects depend on power.
   function automatic route_t route_of(input logic [7:0] c0, input logic [7:0] c1);
      route_t r;
      r = '0;
      r.power = c0[ON_BIT];
      r.speed = c0[SPEED_BIT];
      if (c0[ON_BIT])  // [RULE12]
      begin
         r.plus_sel  = 4'h1 << c1[PCH_LSB +: 2];  // [RULE11]
         r.minus_sel = c1[NCH_BIT] ? 2'h2 : 2'h1;  // [RULE13]
      end
      return r;
   endfunction

   // Two-stage synchronisers; count may tear, read for status only
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ana_s1 <= 2'h0;
         ana_s2 <= 2'h0;
         lat_s1 <= 2'h0;
         lat_s2 <= 2'h0;
         t_s1   <= 8'h00;
         t_s2   <= 8'h00;
      end
      else
      begin
         ana_s1 <= ANALOG_OUT;
         ana_s2 <= ana_s1;
         lat_s1 <= lat_raw;
         lat_s2 <= lat_s1;
         t_s1   <= tcount;
         t_s2   <= t_s1;
      end
   end

   // Timer count crosses clock domains as a plain binary word, so a sample
   // taken mid-increment may tear. Only a value that two successive samples
   // agree on is handed to software; a torn word never reaches the bus.
   // Limitation: while the timer runs faster than half the system clock the
   // held value may lag; it is meant for status reads only.
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         t_s3   <= 8'h00;
         t_hold <= 8'h00;
      end
      else
      begin
         // Third stage gives the previous sample to compare against
         t_s3 <= t_s2;
         if (t_s2 == t_s3)
         begin
            // Steady across two samples: safe to publish
            t_hold <= t_s2;
         end
      end
   end

   // Final outputs and detectors in the system clock domain
   // The previous level is kept in state, so each change of the final
   // output gives exactly one rise or one fall pulse, one cycle long.
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         final_out[i] = cmp_level(st_ff.ctrl0[i], lat_s2[i], ana_s2[i]);  // [RULE16]
      end
      rise = final_out & ~st_ff.out_prev;  // [RULE5]
      fall = ~final_out & st_ff.out_prev;  // [RULE5]
   end

   // Next state: register writes, flags, read data
   // Order inside this process matters: writes come first, then the flag
   // set, so a detected edge overrides a clear written in the same cycle.
   // Read data default to zero, so the bus sees zero outside a read.
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.out_prev = final_out;
      nxt_st.sd = final_out;  // [RULE14]
      nxt_st.rdata = ZERO8;
      for (int i = 0; i < 2; i++)
      begin
         nxt_st.ctrl0[i][OUT_BIT] = final_out[i];
      end
      // Writes; output bit of control 0 is read only
      if (BUS.wr)
      begin
         if (BUS.addr == CTRL0_C1_OFS)
         begin
            nxt_st.ctrl0[0] = {BUS.wdata[7], final_out[0], BUS.wdata[5:0]};
         end
         else if (BUS.addr == CTRL1_C1_OFS)
         begin
            nxt_st.ctrl1[0] = BUS.wdata;
         end
         else if (BUS.addr == CTRL0_C2_OFS)
         begin
            nxt_st.ctrl0[1] = {BUS.wdata[7], final_out[1], BUS.wdata[5:0]};
         end
         else if (BUS.addr == CTRL1_C2_OFS)
         begin
            nxt_st.ctrl1[1] = BUS.wdata;
         end
         else if (BUS.addr == IRQ_FLAG_OFS)
         begin
            nxt_st.flag = st_ff.flag & BUS.wdata[1:0];  // [RULE8]
         end
         else if (BUS.addr == IRQ_EN_OFS)
         begin
            nxt_st.irq_en = BUS.wdata;
         end
         else if (BUS.addr == TIMER_CFG_OFS)
         begin
            nxt_st.presc = BUS.wdata[1:0];
         end
      end
      // Set wins over a same-cycle clear
      for (int i = 0; i < 2; i++)
      begin
         if ((rise[i] && st_ff.ctrl1[i][RISE_BIT]) ||
             (fall[i] && st_ff.ctrl1[i][FALL_BIT]))  // [RULE6]
         begin
            nxt_st.flag[i] = 1'b1;  // [RULE9]
         end
      end
      // Request needs its own, the peripheral and the global enable plus on, polarity and speed
      for (int i = 0; i < 2; i++)
      begin
         nxt_st.irq[i] = st_ff.flag[i] & st_ff.irq_en[i] & st_ff.irq_en[PERIPH_BIT] &
                         st_ff.irq_en[GLOBAL_BIT] & st_ff.ctrl0[i][ON_BIT] &
                         st_ff.ctrl0[i][POL_BIT] & st_ff.ctrl0[i][SPEED_BIT];  // [RULE7]
      end
      // Reads; data appear the cycle after the strobe
      if (BUS.rd)
      begin
         if (BUS.addr == CTRL0_C1_OFS)
         begin
            nxt_st.rdata = st_ff.ctrl0[0];
         end
         else if (BUS.addr == CTRL1_C1_OFS)
         begin
            nxt_st.rdata = st_ff.ctrl1[0];
         end
         else if (BUS.addr == CTRL0_C2_OFS)
         begin
            nxt_st.rdata = st_ff.ctrl0[1];
         end
         else if (BUS.addr == CTRL1_C2_OFS)
         begin
            nxt_st.rdata = st_ff.ctrl1[1];
         end
         else if (BUS.addr == MIRROR_OFS)
         begin
            nxt_st.rdata = {6'h00, st_ff.out_prev};  // [RULE15]
         end
         else if (BUS.addr == IRQ_FLAG_OFS)
         begin
            nxt_st.rdata = {6'h00, st_ff.flag};
         end
         else if (BUS.addr == IRQ_EN_OFS)
         begin
            nxt_st.rdata = st_ff.irq_en;
         end
         else if (BUS.addr == TIMER_OFS)
         begin
            // Filtered count, never a torn sample
            nxt_st.rdata = t_hold;
         end
         else if (BUS.addr == TIMER_CFG_OFS)
         begin
            nxt_st.rdata = {6'h00, st_ff.presc};
         end
      end
   end

   // State register
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_ff <= '{ctrl0: {CTRL0_RST, CTRL0_RST}, ctrl1: {CTRL1_RST, CTRL1_RST},
                    flag: 2'h0, irq_en: ZERO8, presc: PRESC_RST, out_prev: 2'h0,
                    sd: 2'h0, rdata: ZERO8, irq: 2'h0};
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // Outputs
   // Read data and shutdown sources come straight from flip-flops, the request is an OR of two;
   // routes are decoded from registered controls and settle within a cycle.
   assign RDATA        = st_ff.rdata;
   assign ROUTE_C1     = route_of(st_ff.ctrl0[0], st_ff.ctrl1[0]);
   assign ROUTE_C2     = route_of(st_ff.ctrl0[1], st_ff.ctrl1[1]);
   assign SHUTDOWN_SRC = st_ff.sd;
   assign IRQ          = |st_ff.irq;
endmodule

/* File: verif/cmp_backend_props.sv */
// Port-level checker for the comparator back end
module cmp_backend_props
(
   // Clock and reset
   input wire logic              MCLK,
   input wire logic              RST_N,
   // Register port
   input wire cmp_pkg::bus_req_t BUS,
   input wire logic [7:0]        RDATA,
   // Far side
   input wire logic              TMR_CLK,
   input wire logic [1:0]        ANALOG_OUT,
   input wire cmp_pkg::route_t   ROUTE_C1,
   input wire cmp_pkg::route_t   ROUTE_C2,
   input wire logic [1:0]        SHUTDOWN_SRC,
   input wire logic              IRQ
);
   import cmp_pkg::*;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   logic [1:0] shd_q;   // Last final outputs
   logic [2:0] chg_q;   // Recent output changes
   // Change history, so a new request can be traced to an edge
   always_ff @(posedge MCLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         shd_q <= 2'h0;
         chg_q <= 3'h0;
      end
      else
      begin
         shd_q <= SHUTDOWN_SRC;
         chg_q <= {chg_q[1:0], shd_q != SHUTDOWN_SRC};
      end
   end
   // Read of the mirror register
   sequence s_mirror_rd;
      BUS.rd && BUS.addr == MIRROR_OFS;
   endsequence
   // Request up, no write now or just before
   sequence s_irq_quiet;
      IRQ && !BUS.wr && !$past(BUS.wr);
   endsequence
   a_rdata_idle: assert property (!BUS.rd |=> RDATA == ZERO8)
      else $error("read data not zero outside a read");
   a_mirror_read: assert property (s_mirror_rd |=> RDATA == {6'h00, $past(SHUTDOWN_SRC)})
      else $error("mirror read differs from outputs");
   a_route1_off: assert property (!ROUTE_C1.power |-> !ROUTE_C1.plus_sel && !ROUTE_C1.minus_sel)
      else $error("first comparator inputs left connected");
   a_route2_off: assert property (!ROUTE_C2.power |-> !ROUTE_C2.plus_sel && !ROUTE_C2.minus_sel)
      else $error("second comparator inputs left connected");
   a_plus_onehot: assert property (ROUTE_C1.power |-> $onehot(ROUTE_C1.plus_sel))
      else $error("plus input select not one-hot");
   a_minus_onehot: assert property (ROUTE_C2.power |-> $onehot(ROUTE_C2.minus_sel))
      else $error("minus input select not one-hot");
   a_irq_hold: assert property (s_irq_quiet |=> IRQ)
      else $error("request dropped without a write");
   a_irq_cause: assert property ($rose(IRQ) |-> |chg_q || $past(BUS.wr) || $past(BUS.wr, 2))
      else $error("request raised without an edge");
endmodule

bind cmp_backend cmp_backend_props i_props
(
   .MCLK(MCLK), .RST_N(RST_N), .BUS(BUS), .RDATA(RDATA), .TMR_CLK(TMR_CLK),
   .ANALOG_OUT(ANALOG_OUT), .ROUTE_C1(ROUTE_C1), .ROUTE_C2(ROUTE_C2),
   .SHUTDOWN_SRC(SHUTDOWN_SRC), .IRQ(IRQ)
);

/* File: verif/tmr_src_model.sv */
// Timer source clock model, standing still between bursts
module tmr_src_model
(
   // Timer source clock
   output logic TMR_CLK
);
   timeunit 1ns;
   timeprecision 1ps;
   initial TMR_CLK = 1'b0;
   // Whole periods: counting edge, then latching edge
   task automatic pulse(input int n);
      repeat (n)
      begin
         #37 TMR_CLK = 1'b1;
         #37 TMR_CLK = 1'b0;
      end
   endtask
endmodule

/* File: verif/cmp_backend_tb.sv */
// Self-checking bench for the comparator back end
module cmp_backend_tb import cmp_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic       mclk;        // System clock
   logic       rst_n;       // Reset
   bus_req_t   bus;         // Register request
   logic [7:0] rdata;       // Read data
   logic       tmr_clk;     // Timer source clock
   logic [1:0] analog;      // Raw comparator levels
   route_t     rc1;         // First routing
   route_t     rc2;         // Second routing
   logic [1:0] shd;         // Final outputs
   logic       irq;         // Request
   int         err_count;
   int         num_checks;
   int         cyc;         // Timeout count
   int         lat;         // Edges from level change to output

   cmp_backend i_dut (.MCLK(mclk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata),
      .TMR_CLK(tmr_clk), .ANALOG_OUT(analog), .ROUTE_C1(rc1), .ROUTE_C2(rc2),
      .SHUTDOWN_SRC(shd), .IRQ(irq));
   tmr_src_model i_tmr (.TMR_CLK(tmr_clk));

   // 40 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic summarize();
      if (err_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask

   // Read strobe, data taken in the following cycle only
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      @(negedge mclk);
      chk(rdata, exp);
   endtask

   // Bounded wait for the final outputs to move
   task automatic wait_shd(input logic [1:0] old);
      lat = 0;
      while (shd === old && lat < 50)
      begin
         @(negedge mclk);
         lat++;
      end
   endtask

   // Hang guard
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         summarize();
      end
   end

   initial
   begin
      rst_n = 1'b0;
      bus = '0;
      analog = 2'h0;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      // Reset values, unmapped and read-only places
      rd(CTRL0_C1_OFS, CTRL0_RST);
      rd(CTRL1_C2_OFS, CTRL1_RST);
      rd(IRQ_EN_OFS, ZERO8);
      rd(4'hF, ZERO8);
      wr(MIRROR_OFS, 8'hFF);
      rd(MIRROR_OFS, ZERO8);
      // Every plus source, minus pin 1, then power off
      wr(CTRL0_C1_OFS, 8'h84);
      for (int s = 0; s < 4; s++)
      begin
         wr(CTRL1_C1_OFS, 8'(s << PCH_LSB) | 8'h01);
         @(negedge mclk);
         chk({4'h0, rc1.plus_sel}, 8'(1 << s));
         chk({6'h00, rc1.minus_sel}, 8'h02);
      end
      wr(CTRL0_C1_OFS, 8'h04);
      @(negedge mclk);
      chk({4'h0, rc1.plus_sel}, 8'h00);
      // Falling edge only enabled; turn-on rise must not flag
      wr(CTRL1_C1_OFS, 8'h40);
      wr(CTRL0_C1_OFS, 8'h94);
      wr(IRQ_EN_OFS, 8'h41);
      rd(IRQ_FLAG_OFS, ZERO8);
      @(posedge mclk);
      analog <= 2'h1;
      wait_shd(2'h1);
      repeat (4) @(negedge mclk);
      chk(irq, 1'b0);
      chk({6'h00, shd}, 8'h00);
      rd(IRQ_FLAG_OFS, 8'h01);
      rd(MIRROR_OFS, 8'h00);
      wr(IRQ_EN_OFS, 8'hC1);
      repeat (3) @(negedge mclk);
      chk(irq, 1'b1);
      repeat (20) @(negedge mclk);
      chk(irq, 1'b1);
      wr(IRQ_FLAG_OFS, 8'h00);
      repeat (3) @(negedge mclk);
      chk(irq, 1'b0);
      // Clear lands on the edge that sets the flag: the output register
      // moves on the same edge as the flag, lat-1 edges after the level change, so the write goes out one edge earlier
      wr(CTRL1_C1_OFS, 8'hC0);
      @(posedge mclk);
      analog <= 2'h0;
      repeat (lat - 2) @(posedge mclk);
      bus <= '{addr: IRQ_FLAG_OFS, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
      rd(IRQ_FLAG_OFS, 8'h01);
      wr(IRQ_FLAG_OFS, 8'h00);
      // Polarity toggle on a powered-down comparator
      wr(CTRL1_C2_OFS, 8'h80);
      wr(CTRL0_C2_OFS, 8'h14);
      rd(IRQ_FLAG_OFS, 8'h02);
      wr(IRQ_FLAG_OFS, 8'h00);
      // Synchronized path holds until the timer clock falls
      wr(CTRL0_C1_OFS, 8'h95);
      i_tmr.pulse(1);
      @(posedge mclk);
      analog <= 2'h1;
      repeat (10) @(negedge mclk);
      chk({7'h00, shd[0]}, 8'h01);
      i_tmr.pulse(5);
      repeat (4) @(negedge mclk);
      chk({7'h00, shd[0]}, 8'h00);
      rd(TIMER_OFS, 8'h06);
      // Prescale by eight
      wr(TIMER_CFG_OFS, 8'h03);
      rd(TIMER_CFG_OFS, 8'h03);
      @(posedge mclk);
      analog <= 2'h0;
      i_tmr.pulse(16);
      repeat (4) @(negedge mclk);
      chk({7'h00, shd[0]}, 8'h01);
      rd(TIMER_OFS, 8'h08);
      summarize();
   end
endmodule
